//--- rtl/gpio_matrix_output_enable_select.sv
// Output-enable and signal routing matrix for all pins, with input defaults.
//
// What this block does
// R01: Select bit 1: pad enable follows software per-pin enable bit.
// R02: Select bit 0: pad enable comes from the routed peripheral's enable.
// R03: Peripherals with constant-one enable keep the pin enabled when select is 0.
// R04: Unassigned signal indices carry no peripheral signal.
// R05: Software picks only named inputs as input routing targets.
// R06: Software picks only named outputs as a pin's output source.
// R07: Output index field picks the peripheral output driving the pin.
// R08: Index 128 drives the software output value bit instead.
// R09: Invert bit inverts the routed output value before the pad.
// R10: Output indices 97 to 100 connect straight to input indices 97 to 100.
// R11: Unrouted valid inputs receive their constant default value.
`default_nettype none
module gpio_matrix_output_enable_select
    import gpio_oe_pkg::*;
#(
    parameter int PINS = PIN_COUNT,
    parameter int SIGNALS = SIGNAL_COUNT,
    parameter logic [SIGNALS-1:0] OUT_VALID = '1,
    parameter logic [SIGNALS-1:0] IN_VALID = '1,
    parameter logic [SIGNALS-1:0] IN_DEFAULT = '0
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic cfg_we,
    input wire logic [4:0] cfg_pin,
    input wire logic [INDEX_WIDTH-1:0] cfg_output_signal_index_select,
    input wire logic cfg_output_enable_source_select,
    input wire logic cfg_output_invert_select,
    input wire logic [PINS-1:0] enable_bits,
    input wire logic [PINS-1:0] out_value_bits,
    input wire logic [SIGNALS-1:0] periph_out,
    input wire logic [SIGNALS-1:0] periph_oe,
    input wire logic [PINS-1:0] pad_in,
    input wire logic [SIGNALS-1:0] in_route_valid,
    input wire logic [SIGNALS*5-1:0] in_route_pin,
    output logic [PINS-1:0] pad_out,
    output logic [PINS-1:0] pad_oe,
    output logic [SIGNALS-1:0] periph_in,
    output logic [PINS*INDEX_WIDTH-1:0] index_readback
);
    logic [INDEX_WIDTH-1:0] index_q [PINS];
    logic [INDEX_WIDTH-1:0] index_d [PINS];
    logic [PINS-1:0] oe_sel_q, oe_sel_d;
    logic [PINS-1:0] inv_q, inv_d;
    logic [PINS-1:0] en_q, en_d;
    logic [PINS-1:0] val_q, val_d;
    logic [PINS-1:0] pad_out_d, pad_oe_d;
    logic [SIGNALS-1:0] periph_in_d;
    logic [SIGNALS-1:0] loop_in;

    // Configuration next state
    always_comb begin
        for (int p = 0; p < PINS; p++) begin
            index_d[p] = index_q[p];
        end
        oe_sel_d = oe_sel_q;
        inv_d = inv_q;
        en_d = enable_bits;
        val_d = out_value_bits;
        if (cfg_we && int'(cfg_pin) < PINS) begin
            index_d[cfg_pin] = cfg_output_signal_index_select; // R07
            oe_sel_d[cfg_pin] = cfg_output_enable_source_select;
            inv_d[cfg_pin] = cfg_output_invert_select;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            for (int p = 0; p < PINS; p++) begin
                index_q[p] <= INDEX_RESET;
            end
            oe_sel_q <= {PINS{OE_SOURCE_SELECT_RESET}};
            inv_q <= {PINS{INVERT_SELECT_RESET}};
            en_q <= {PINS{ENABLE_RESET}};
            val_q <= {PINS{OUT_VALUE_RESET}};
        end else if (clk_en) begin
            index_q <= index_d;
            oe_sel_q <= oe_sel_d;
            inv_q <= inv_d;
            en_q <= en_d;
            val_q <= val_d;
        end
    end

    // Input side: routed pin value or constant default
    always_comb begin
        for (int s = 0; s < SIGNALS; s++) begin
            periph_in_d[s] = IN_DEFAULT[s]; // R11
            if (IN_VALID[s] && in_route_valid[s] && int'(in_route_pin[s*5 +: 5]) < PINS) begin
                periph_in_d[s] = pad_in[in_route_pin[s*5 +: 5]]; // R05
            end
            if (!IN_VALID[s]) begin
                periph_in_d[s] = 1'b0; // R04
            end
        end
    end
    assign loop_in = periph_in_d; // R10

    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : g_pin
            pin_out_slice #(.SIGNALS(SIGNALS)) u_slice (
                .index_sel(index_q[g]),
                .oe_source_sel(oe_sel_q[g]),
                .invert_sel(inv_q[g]),
                .sw_enable(en_q[g]),
                .sw_value(val_q[g]),
                .periph_out(periph_out),
                .periph_oe(periph_oe),
                .out_valid(OUT_VALID), // R06
                .loop_in(loop_in),
                .pad_value(pad_out_d[g]),
                .pad_oe(pad_oe_d[g])
            );
            assign index_readback[g*INDEX_WIDTH +: INDEX_WIDTH] = index_q[g];
        end
    endgenerate

    // Registered pad and peripheral outputs
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pad_out <= '0;
            pad_oe <= '0;
            periph_in <= '0;
        end else if (clk_en) begin
            pad_out <= pad_out_d;
            pad_oe <= pad_oe_d; // R01 R02
            periph_in <= periph_in_d;
        end
    end
endmodule
`default_nettype wire

//--- rtl/gpio_oe_pkg.sv
// Constants and types shared by the output-enable select matrix.
`default_nettype none
package gpio_oe_pkg;
    localparam int PIN_COUNT = 21;
    localparam int SIGNAL_COUNT = 128;
    localparam int INDEX_WIDTH = 8;
    localparam logic [7:0] SW_OUTPUT_INDEX = 8'h80;
    localparam logic [7:0] LOOP_FIRST_INDEX = 8'h61;
    localparam logic [7:0] LOOP_LAST_INDEX = 8'h64;
    localparam logic [7:0] INDEX_RESET = 8'h80;
    localparam logic OE_SOURCE_SELECT_RESET = 1'b0;
    localparam logic INVERT_SELECT_RESET = 1'b0;
    localparam logic ENABLE_RESET = 1'b0;
    localparam logic OUT_VALUE_RESET = 1'b0;
    typedef enum logic [1:0] {
        SRC_NONE_type,
        SRC_PERIPH_type,
        SRC_LOOP_type,
        SRC_SOFTWARE_type
    } source_kind_type;
endpackage
`default_nettype wire

//--- rtl/pin_out_slice.sv
// One pin's output path: value select, inversion and enable select.
`default_nettype none
module pin_out_slice
    import gpio_oe_pkg::*;
#(
    parameter int SIGNALS = SIGNAL_COUNT
) (
    input wire logic [INDEX_WIDTH-1:0] index_sel,
    input wire logic oe_source_sel,
    input wire logic invert_sel,
    input wire logic sw_enable,
    input wire logic sw_value,
    input wire logic [SIGNALS-1:0] periph_out,
    input wire logic [SIGNALS-1:0] periph_oe,
    input wire logic [SIGNALS-1:0] out_valid,
    input wire logic [SIGNALS-1:0] loop_in,
    output logic pad_value,
    output logic pad_oe
);
    source_kind_type kind;
    logic raw_value;
    logic raw_oe;

    always_comb begin
        kind = SRC_NONE_type;
        raw_value = 1'b0;
        raw_oe = 1'b0;
        if (index_sel == SW_OUTPUT_INDEX) begin
            kind = SRC_SOFTWARE_type;
            raw_value = sw_value; // R08
            raw_oe = sw_enable;
        end else if (index_sel >= LOOP_FIRST_INDEX && index_sel <= LOOP_LAST_INDEX) begin
            kind = SRC_LOOP_type;
            raw_value = loop_in[index_sel[6:0]]; // R10
            raw_oe = 1'b1;
        end else if (index_sel < INDEX_WIDTH'(SIGNALS) && out_valid[index_sel[6:0]]) begin
            kind = SRC_PERIPH_type;
            raw_value = periph_out[index_sel[6:0]]; // R07
            raw_oe = periph_oe[index_sel[6:0]]; // R03
        end
        // Unassigned index carries nothing: value 0, no peripheral enable
        if (kind == SRC_NONE_type) begin
            raw_value = 1'b0; // R04
            raw_oe = 1'b0;
        end
        pad_value = raw_value ^ invert_sel; // R09
        pad_oe = oe_source_sel ? sw_enable : raw_oe; // R01 R02
    end
endmodule
`default_nettype wire

//--- tb/gpio_oe_sva.sv
// Checker for pin 0 output path, reset, freeze and input default
`default_nettype none
module gpio_oe_sva
    import gpio_oe_pkg::*;
#(
    parameter int PINS = PIN_COUNT,
    parameter int SIGNALS = SIGNAL_COUNT,
    parameter logic [SIGNALS-1:0] OUT_VALID = '1
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic cfg_we,
    input wire logic [4:0] cfg_pin,
    input wire logic [INDEX_WIDTH-1:0] cfg_output_signal_index_select,
    input wire logic cfg_output_enable_source_select,
    input wire logic cfg_output_invert_select,
    input wire logic [PINS-1:0] enable_bits,
    input wire logic [PINS-1:0] out_value_bits,
    input wire logic [SIGNALS-1:0] periph_oe,
    input wire logic [SIGNALS-1:0] in_route_valid,
    input wire logic [PINS-1:0] pad_out,
    input wire logic [PINS-1:0] pad_oe,
    input wire logic [SIGNALS-1:0] periph_in,
    input wire logic [PINS*INDEX_WIDTH-1:0] index_readback
);
    timeunit 1ns;
    timeprecision 100ps;
    logic oe_h, inv_h;
    logic poe_q;
    wire logic [7:0] ix = index_readback[7:0];
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // Mirror of pin 0 enable source and invert bits
    always_ff @(posedge clock)
        if (sys_rst) {oe_h, inv_h} <= 2'h0;
        else if (clk_en && cfg_we && cfg_pin == 5'h00)
            {oe_h, inv_h} <= {cfg_output_enable_source_select, cfg_output_invert_select};
    // Enable of the peripheral that pin 0 selects, one cycle late
    always_ff @(posedge clock) poe_q <= periph_oe[ix[6:0]];
    sequence s_live; clk_en ##1 clk_en; endsequence
    property p_rst;
        disable iff (1'b0) sys_rst && clk_en |=> pad_oe == '0 && ix == 8'h80;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state");
    property p_cfg;
        cfg_we && clk_en && cfg_pin == 5'h00 |=> ix == $past(cfg_output_signal_index_select);
    endproperty
    a_cfg: assert property (p_cfg) else $error("index write");
    property p_frz; !clk_en |=> $stable(pad_oe) && $stable(index_readback); endproperty
    a_frz: assert property (p_frz) else $error("freeze");
    // Config seen at the launching edge; software bits pass two register stages
    property p_en; s_live ##0 oe_h |=> pad_oe[0] == $past(enable_bits[0], 2); endproperty
    a_en: assert property (p_en) else $error("sw enable");
    property p_per;
        s_live ##0 !oe_h && ix < 8'h61 && OUT_VALID[ix] |=> pad_oe[0] == poe_q;
    endproperty
    a_per: assert property (p_per) else $error("periph enable");
    property p_gap;
        s_live ##0 !oe_h && ix < 8'h61 && !OUT_VALID[ix] |=> !pad_oe[0];
    endproperty
    a_gap: assert property (p_gap) else $error("gap index");
    property p_sw;
        s_live ##0 ix == 8'h80 |=> pad_out[0] == ($past(out_value_bits[0], 2) ^ $past(inv_h));
    endproperty
    a_sw: assert property (p_sw) else $error("sw value");
    property p_def; s_live ##0 !$past(in_route_valid[0]) |-> !periph_in[0]; endproperty
    a_def: assert property (p_def) else $error("input default");
endmodule
`default_nettype wire

//--- tb/periph_model.sv
// Peripheral side: outputs and enables by signal index
`default_nettype none
module periph_model (
    input wire logic [127:0] pat,
    output logic [127:0] periph_out,
    output logic [127:0] periph_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    assign periph_out = pat;
    assign periph_oe = pat | 128'h7E00000078FC0;
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Testbench for the output-enable select matrix
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock, sys_rst, clk_en, cfg_we;
    logic cfg_output_enable_source_select, cfg_output_invert_select;
    logic [4:0] cfg_pin;
    logic [7:0] cfg_output_signal_index_select;
    logic [20:0] enable_bits, out_value_bits, pad_in, pad_out, pad_oe;
    logic [127:0] pat, periph_out, periph_oe, periph_in, in_route_valid;
    logic [639:0] in_route_pin;
    logic [167:0] index_readback;
    int errors, cmp_count;
    periph_model peer (.*);
    gpio_matrix_output_enable_select #(.OUT_VALID(~128'h7000),
        .IN_DEFAULT(128'h60000000000000)) dut (.*);
    task cyc(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask
    task chk(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: pin bit", $time);
        end
    endtask
    task wr(input logic [7:0] ix, input logic oe, input logic inv);
        {cfg_we, cfg_output_signal_index_select} = {1'b1, ix};
        {cfg_output_enable_source_select, cfg_output_invert_select} = {oe, inv};
        cyc(1);
        cfg_we = 1'b0;
        cyc(2);
    endtask
    task t_sw;
        {enable_bits[0], out_value_bits[0]} = 2'h3;
        wr(8'h80, 1'b1, 1'b0);
        chk(pad_out[0], 1'b1);
        chk(pad_oe[0], 1'b1);
        enable_bits[0] = 1'b0;
        wr(8'h80, 1'b1, 1'b1);
        chk(pad_out[0], 1'b0);
        chk(pad_oe[0], 1'b0);
    endtask
    task t_per;
        pat = 128'h1;
        wr(8'h00, 1'b0, 1'b0);
        chk(pad_out[0], 1'b1);
        pat = 128'h0;
        cyc(2);
        chk(pad_oe[0], 1'b0);
        wr(8'h06, 1'b0, 1'b0);
        chk(pad_oe[0], 1'b1);
        wr(8'h06, 1'b1, 1'b0);
        chk(pad_oe[0], 1'b0);
        pat = 128'h1000;
        wr(8'h0C, 1'b0, 1'b0);
        chk(pad_oe[0], 1'b0);
        chk(pad_out[0], 1'b0);
    endtask
    task t_loop;
        {in_route_valid[97], in_route_pin[489:485], pad_in[1]} = 7'h43;
        wr(8'h61, 1'b0, 1'b0);
        chk(pad_out[0], 1'b1);
        chk(periph_in[53], 1'b1);
        {clk_en, pad_in[1]} = 2'h0;
        cyc(3);
        chk(pad_out[0], 1'b1);
        {clk_en, sys_rst} = 2'h3;
        cyc(1);
        sys_rst = 1'b0;
        chk(index_readback[7:0] === 8'h80, 1'b1);
        chk(pad_oe[0], 1'b0);
        chk(pad_out[0], 1'b0);
        cyc(2);
        chk(pad_out[0], 1'b1);
        chk(pad_oe[0], 1'b0);
    endtask
    task conclude;
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    initial begin
        #100us;
        errors++;
        conclude;
    end
    initial begin
        {sys_rst, clk_en, cfg_we, cfg_pin, cfg_output_signal_index_select} = {2'h3, 14'h0};
        {cfg_output_enable_source_select, cfg_output_invert_select} = 2'h0;
        {enable_bits, out_value_bits, pad_in, pat, in_route_valid, in_route_pin} = '0;
        cyc(12);
        sys_rst = 1'b0;
        t_sw;
        t_per;
        t_loop;
        conclude;
    end
endmodule
bind gpio_matrix_output_enable_select gpio_oe_sva #(.PINS(PINS), .SIGNALS(SIGNALS),
    .OUT_VALID(OUT_VALID)) chk (.*);
`default_nettype wire
